/* File: verilog/l1rt_pkg.sv */
// Purpose: shared constants and types for the L1 entry rejection timer
// Assumes: 32-bit APB register access, one clock
// Notes:   one control register, one status register
package l1rt_pkg;
   // register map
   localparam logic [11:0] L1RT_CTL_OFFSET       = 12'h710;
   localparam logic [11:0] L1RT_STAT_OFFSET      = 12'h714;
   // field layout of the control register
   localparam int          L1RT_INTERVAL_LSB     = 0;
   localparam int          L1RT_INTERVAL_W       = 14;
   localparam int          L1RT_START_SEL_BIT    = 16;
   // reset values
   localparam logic [13:0] L1RT_INTERVAL_RST     = 14'h0947;
   localparam logic        L1RT_START_SEL_RST    = 1'b1;
   // timing: one count is one period of the timer clock
   localparam int          L1RT_TICK_NS          = 4;
   localparam int          L1RT_CLK_PERIOD_NS    = 100;
   localparam int          L1RT_CYC_PER_TICK     = (L1RT_TICK_NS + L1RT_CLK_PERIOD_NS - 1) / L1RT_CLK_PERIOD_NS;

   // apb request bundle
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } l1rt_apb_req_type;

   // link events seen by the timer
   typedef struct packed {
      logic nak_sent;
      logic req_rcvd;
   } l1rt_evt_type;
endpackage : l1rt_pkg

/* File: verilog/l1rt_counter.sv */
// Purpose: down counter of the rejection wait
// Assumes: load has priority over counting
// Notes:   running is high while a nonzero count remains
`timescale 1ns/1ps
module l1rt_counter (
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   input  wire logic        load_i,
   input  wire logic [13:0] value_i,
   input  wire logic        tick_i,
   output logic [13:0]      count_o,
   output logic             running_o
);
   logic [13:0] count_q;
   logic [13:0] count_d;

   // next count: load, else decrement on tick
   assign count_d   = load_i ? value_i :
                      ((tick_i && count_q != 14'h0000) ? count_q - 14'h0001 : count_q);
   assign count_o   = count_q;
   assign running_o = (count_q != 14'h0000);

   // count register
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         count_q <= 14'h0000;
      end else begin
         count_q <= count_d;
      end
   end
endmodule : l1rt_counter

/* File: verilog/l1rt_timer.sv */
// Purpose: L1 entry rejection timer with APB control register
// Assumes: link events are one-cycle pulses from same-clock logic
// Notes:   counts clock cycles of REF_CLK_I as timer ticks
//
// Operation
// - a 14-bit minimum interval in bits 13:0 sets the least wait in timer cycles between two requests.
// - the interval resets to 0x947 (2375) and is read/write by software.
// - each interval count is one 4 ns timer period; the code counts one 100 ns REF_CLK_I cycle per count.
// - the partner sends request DLLPs and the port answers with an acknowledge or a refusal.
// - after refusing a request the port counts the interval before taking any new request.
// - a select bit at 16, reset 1, chooses request handling, and the timer starts on the refusal message.
// - with select 0 each request DLLP during the wait restarts the timer.
// - with select 1 request DLLPs during the wait are ignored and the count keeps stepping down.
// - after expiry the next request DLLP is flagged as a new request.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
module l1rt_timer
   import l1rt_pkg::*;
(
   input  wire logic                       REF_CLK_I,
   input  wire logic                       RESETN_I,
   input  wire l1rt_pkg::l1rt_apb_req_type APB_REQ_I,
   output logic [31:0]                     PRDATA_O,
   output logic                            PREADY_O,
   output logic                            PSLVERR_O,
   input  wire l1rt_pkg::l1rt_evt_type     EVT_I,
   output logic                            NEW_REQ_O,
   output logic                            TIMER_BUSY_O
);
   import l1rt_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // helper functions
   // address match of one register word
   function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] offset);
      return addr == offset;
   endfunction : addr_hit

   // a nonzero count keeps the timer busy
   function automatic logic count_live(input logic [13:0] value);
      return value != 14'h0000;
   endfunction : count_live

   ////////////////////////////////////////////////////////////////////////////
   // register bus
   logic [13:0] interval_q;
   logic        start_sel_q;
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;
   logic        new_req_q;
   logic        busy_q;
   logic [13:0] count;
   logic        running;

   // decode of setup phase; answer one cycle later
   wire         setup     = APB_REQ_I.psel && !APB_REQ_I.penable;
   wire         access_ph = APB_REQ_I.psel && APB_REQ_I.penable && pready_q;
   wire         hit_ctl   = addr_hit(APB_REQ_I.paddr, L1RT_CTL_OFFSET);
   wire         hit_stat  = addr_hit(APB_REQ_I.paddr, L1RT_STAT_OFFSET);
   // a write lands at the edge that completes the access phase
   wire         wr_ctl    = access_ph && APB_REQ_I.pwrite && hit_ctl;
   wire [31:0]  ctl_word = {15'h0000, start_sel_q, 2'h0, interval_q};
   wire [31:0]  st_word  = {17'h00000, running, count};
   wire [31:0]  rd_word  = hit_ctl ? ctl_word : (hit_stat ? st_word : 32'h00000000);

   // control register, written when the access completes
   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         interval_q  <= L1RT_INTERVAL_RST;
         start_sel_q <= L1RT_START_SEL_RST;
      end else if (wr_ctl) begin
         interval_q  <= APB_REQ_I.pwdata[L1RT_INTERVAL_LSB +: L1RT_INTERVAL_W];
         start_sel_q <= APB_REQ_I.pwdata[L1RT_START_SEL_BIT];
      end
   end

   // no wait state response: ready in the first access cycle
   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h00000000;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup && !(hit_ctl || (hit_stat && !APB_REQ_I.pwrite));
         prdata_q  <= (setup && !APB_REQ_I.pwrite) ? rd_word : 32'h00000000;
      end
   end

   assign PRDATA_O  = prdata_q;
   assign PREADY_O  = pready_q;
   assign PSLVERR_O = pslverr_q;

   ////////////////////////////////////////////////////////////////////////////
   // rejection timer
   // one tick per clock: the clock is slower than the 4 ns tick
   wire tick    = (L1RT_CYC_PER_TICK >= 1);
   // start on refusal; restart on request only with select 0
   wire restart = EVT_I.req_rcvd && running && !start_sel_q;
   wire load    = EVT_I.nak_sent || restart;
   // a request after expiry counts as new
   wire is_new  = EVT_I.req_rcvd && !running && !EVT_I.nak_sent;

   l1rt_counter u_counter (
      .clk_i     (REF_CLK_I),
      .resetn_i  (RESETN_I),
      .load_i    (load),
      .value_i   (interval_q),  // sampled at load
      .tick_i    (tick),
      .count_o   (count),
      .running_o (running)
   );

   // registered event outputs
   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         new_req_q <= 1'b0;
         busy_q    <= 1'b0;
      end else begin
         new_req_q <= is_new;
         busy_q    <= load ? count_live(interval_q) : (count > 14'h0001);
      end
   end

   assign NEW_REQ_O    = new_req_q;
   assign TIMER_BUSY_O = busy_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_nak;
      EVT_I.nak_sent;
   endsequence

   a_nak_loads_count: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      s_nak |=> (count == $past(interval_q))) else $error("count not loaded on refusal");
   a_ignore_keeps_count: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      (EVT_I.req_rcvd && running && start_sel_q && !EVT_I.nak_sent) |=> (count == $past(count) - 14'h0001))
      else $error("ignored request changed count");
   a_restart_reloads: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      (EVT_I.req_rcvd && running && !start_sel_q) |=> (count == $past(interval_q)))
      else $error("request did not restart timer");
   a_new_after_expiry: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      (EVT_I.req_rcvd && !running && !EVT_I.nak_sent) |=> NEW_REQ_O) else $error("new request not flagged");
   a_no_new_while_busy: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      running |=> !NEW_REQ_O) else $error("request flagged during wait");
   a_count_decrements: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      (running && !load) |=> (count == $past(count) - 14'h0001)) else $error("count did not step");
   a_busy_matches: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      TIMER_BUSY_O == running) else $error("busy output disagrees with counter");
   a_write_interval: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      wr_ctl |=> (interval_q == $past(APB_REQ_I.pwdata[13:0]))) else $error("interval not written");
   a_ready_one_wait: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      setup |=> PREADY_O) else $error("ready not one cycle after setup");

   ////////////////////////////////////////////////////////////////////////////
   // checks on the multi-step timer behaviour
   // refusal that arms a nonzero wait
   sequence s_refusal_armed;
      EVT_I.nak_sent && count_live(interval_q);
   endsequence

   // refusal whose wait covers at least the next two cycles
   sequence s_refusal_long;
      EVT_I.nak_sent && (interval_q > 14'h0001);
   endsequence

   // request dllp on an idle timer
   sequence s_req_idle;
      EVT_I.req_rcvd && !running && !EVT_I.nak_sent;
   endsequence

   // request dllp during the wait with restart selected
   sequence s_req_restart;
      EVT_I.req_rcvd && running && !start_sel_q;
   endsequence

   // request dllp during the wait with ignore selected
   sequence s_req_ignored;
      EVT_I.req_rcvd && running && start_sel_q && !EVT_I.nak_sent;
   endsequence

   // read of the control word in its setup cycle
   sequence s_read_ctl;
      setup && !APB_REQ_I.pwrite && hit_ctl;
   endsequence

   // start, restart and ignore
   a_busy_on_refusal: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      s_refusal_armed |=> TIMER_BUSY_O) else $error("timer not busy after refusal");
   a_req_after_nak: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      s_refusal_long ##[1:2] EVT_I.req_rcvd |=> !NEW_REQ_O)
      else $error("request soon after refusal flagged");
   a_restart_busy: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      s_req_restart |=> (TIMER_BUSY_O == count_live($past(interval_q))))
      else $error("restart lost busy state");
   a_ignored_not_new: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      s_req_ignored |=> !NEW_REQ_O) else $error("ignored request flagged as new");

   // expiry, new requests and a control write during the wait
   a_expiry_clears: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      (count == 14'h0001 && !load) |=> !TIMER_BUSY_O) else $error("busy after last count");
   a_idle_stays_zero: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      (!running && !load) |=> (count == 14'h0000)) else $error("idle count moved");
   a_idle_req_flag: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      s_req_idle |=> (NEW_REQ_O && !TIMER_BUSY_O)) else $error("idle request not taken as new");
   a_interval_latched: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      (wr_ctl && running && !load) |=> (count == $past(count) - 14'h0001))
      else $error("write disturbed running count");

   // register access
   a_read_ctl_word: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      s_read_ctl |=> (PRDATA_O[13:0] == $past(interval_q)) && (PRDATA_O[16] == $past(start_sel_q))
         && (PRDATA_O[15:14] == 2'h0) && (PRDATA_O[31:17] == 15'h0000)) else $error("control word read wrong");
   a_stat_read: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      (setup && !APB_REQ_I.pwrite && hit_stat) |=> (PRDATA_O[13:0] == $past(count))
         && (PRDATA_O[14] == $past(running))) else $error("status word read wrong");
   a_write_select: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      wr_ctl |=> (start_sel_q == $past(APB_REQ_I.pwdata[16]))) else $error("select not written");
   a_ctl_held: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      !wr_ctl |=> ($stable(interval_q) && $stable(start_sel_q))) else $error("control changed without write");
   a_err_unmapped: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      (setup && !hit_ctl && !hit_stat) |=> (PSLVERR_O && (PRDATA_O == 32'h00000000)))
      else $error("unmapped access not refused");
   a_ok_ctl: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      (setup && hit_ctl) |=> (PREADY_O && !PSLVERR_O)) else $error("control access refused");
   a_ready_pulse: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      PREADY_O |=> !PREADY_O) else $error("ready held past access");
endmodule : l1rt_timer

/* File: verification/l1rt_partner.sv */
// Purpose: link-side model raising event pulses
// Assumes: one pulse per call
// Notes:   refusal and request share one task
`timescale 1ns/1ps
module l1rt_partner
   import l1rt_pkg::*;
(
   input  wire logic              clk_i,
   output l1rt_pkg::l1rt_evt_type evt_o
);
   initial evt_o = '0;
   // one-cycle pulse: request dllp or refusal message
   task automatic send(input logic nak);
      @(posedge clk_i) evt_o <= nak ? 2'h2 : 2'h1;
      @(posedge clk_i) evt_o <= '0;
   endtask : send
endmodule : l1rt_partner

/* File: verification/l1_aspm_rejection_timer_tb.sv */
// Purpose: self-checking bench of the rejection timer
// Assumes: one count per clock cycle
// Notes:   apb answers in the access cycle
`timescale 1ns/1ps
module l1_aspm_rejection_timer_tb;
   import l1rt_pkg::*;
   logic             clk = 1'b0;
   logic             rstn = 1'b0;
   l1rt_apb_req_type req = '0;
   l1rt_evt_type     evt;
   logic [31:0]      prdata, rd;
   logic             pready, pslverr, new_req, busy, er;
   int               err_total = 0, compares = 0, n;
   always #50 clk = ~clk;
   l1rt_timer dut (.REF_CLK_I(clk), .RESETN_I(rstn), .APB_REQ_I(req), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .EVT_I(evt), .NEW_REQ_O(new_req), .TIMER_BUSY_O(busy));
   l1rt_partner p (.clk_i(clk), .evt_o(evt));
   ////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // one apb transfer, held until pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge clk) req <= '{1'b1, 1'b0, wr, a, d};
      @(posedge clk) req.penable <= 1'b1;
      for (i = 0; i < 8; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (i == 8) end_of_test(1);
      rd = prdata;
      er = pslverr;
      req <= '0;
   endtask : apb
   // cycles the timer still reports busy
   task automatic blen();
      n = 0;
      for (int i = 0; i < 3000; i++) begin
         @(posedge clk);
         if (busy !== 1'b1) return;
         n++;
      end
      end_of_test(1);
   endtask : blen
   // refusal then request two cycles later, then expiry
   task automatic t_wait(input logic [31:0] ctl, input logic [31:0] exp_n);
      apb(1'b1, L1RT_CTL_OFFSET, ctl);
      apb(1'b0, L1RT_CTL_OFFSET, 32'h0);
      chk("ctl", ctl, rd);
      chk("ctl_err", 32'h0, {31'h0, er});
      p.send(1'b1);
      p.send(1'b0);
      @(posedge clk);
      chk("new_busy", 32'h0, {31'h0, new_req});
      blen();
      chk("remain", exp_n, 32'(n));
      p.send(1'b0);
      @(posedge clk);
      chk("new_idle", 32'h1, {31'h0, new_req});
   endtask : t_wait
   task automatic t_reset();
      apb(1'b0, L1RT_CTL_OFFSET, 32'h0);
      chk("ctl_rst", 32'h0001_0947, rd);
      p.send(1'b1);
      blen();
      chk("wait_rst", 32'h947, 32'(n));
   endtask : t_reset
   // status word during a wait; a write mid-wait leaves the count alone
   task automatic t_status();
      apb(1'b1, L1RT_CTL_OFFSET, 32'h0000_0020);
      p.send(1'b1);
      apb(1'b0, L1RT_STAT_OFFSET, 32'h0);
      chk("stat", 32'h0000_401F, rd);
      chk("stat_err", 32'h0, {31'h0, er});
      apb(1'b1, L1RT_CTL_OFFSET, 32'h0001_0947);
      blen();
      chk("wait_mid_wr", 32'h1A, 32'(n));
   endtask : t_status
   task automatic t_refuse();
      apb(1'b0, 12'h718, 32'h0);
      chk("unmapped", 32'h1, {31'h0, er});
      chk("unmapped_rd", 32'h0, rd);
      apb(1'b1, L1RT_STAT_OFFSET, 32'h3);
      chk("stat_wr", 32'h1, {31'h0, er});
   endtask : t_refuse
   task automatic end_of_test(input bit hang);
      if (hang) err_total++;
      if (err_total == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_of_test
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_wait(32'h0001_000A, 32'h7);
      t_wait(32'h0000_000A, 32'h9);
      t_status();
      t_refuse();
      end_of_test(0);
   end
endmodule : l1_aspm_rejection_timer_tb
